// ==== hdl/dtac_core.sv ====
`timescale 1ns/1ps
module dtac_core
  import dtac_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  // Register port
  input  wire dtac_req_s    reg_req,
  output logic [31:0]       reg_rdata,
  // Source clock pins and divisor value
  input  wire logic         osc_clk_pin,
  input  wire logic         sine_clk_pin,
  input  wire logic         digital_clk_pin,
  input  wire logic [15:0]  clock_divisor_value,
  // Trigger and converter inputs
  input  wire logic         external_logic_trigger_input,
  input  wire dtac_sample_s adc_sample,
  // Sample buffer side
  input  wire logic         buffer_pop,
  output logic              sample_push,
  output dtac_sample_s      sample_data,
  output logic              buffer_flush,
  // Status outputs
  output logic              sampling_active,
  output logic              sample_tick,
  output logic              freq_select
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Register write hit decode, used for every register write
  function automatic logic hit(input dtac_req_s r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // Only the five defined codes are legal modes
  function automatic logic mode_legal(input logic [2:0] m);
    mode_legal = (m <= MODE_MIDDLE);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]        trigger_mode_code;       // Mode field
  logic [7:0]        trigger_threshold_code;  // Offset binary level
  logic [2:0]        trigger_origin_code;     // Source select
  logic              trigger_direction;       // 0 rising, 1 falling
  logic [15:0]       after_trigger_count_value; // Down counter
  logic              sampling_arm_bit;        // Arm request
  logic [1:0]        sample_clock_origin;     // Source clock select
  logic              trigger_seen_flag;       // Sticky trigger flag
  logic [BUF_AW-1:0] buf_level;               // Buffer occupancy
  dtac_state_e       state;                   // Acquisition state
  dtac_state_e       next_state;              // Next acquisition state
  logic [2:0]        clk_s1;                  // Source clock stage 1
  logic [2:0]        clk_s2;                  // Source clock stage 2
  logic [2:0]        clk_prev;                // Source clock history
  logic              trg_s1;                  // Trigger pin stage 1
  logic              trg_s2;                  // Trigger pin stage 2
  logic              trg_prev;                // Trigger pin history
  dtac_sample_s      adc_s1;                  // Converter stage 1
  dtac_sample_s      adc_s2;                  // Converter stage 2
  logic [7:0]        chan_prev;               // Previous channel code
  logic              chan_prev_ok;            // History is valid
  logic [15:0]       div_cnt;                 // Divider counter
  logic              src_edge;                // Selected source edge
  logic [15:0]       divisor;                 // Effective divisor
  logic [7:0]        chan_now;                // Selected channel code
  logic              analog_cross;            // Level crossing seen
  logic              digital_edge;            // Pin edge seen
  logic              trig_event;              // Trigger condition met
  logic              waiting;                 // States that look for trigger
  logic              sampling;                // States that store samples
  logic              buf_full;                // Buffer cannot accept
  logic              do_push;                 // Sample stored this cycle
  logic              do_pop;                  // Sample drained this cycle
  logic              flush_req;               // Flush written
  logic              count_run;               // Counter decrement enable

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------

  // Write-only configuration, unused bits ignored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trigger_mode_code      <= RST_MODE;
      trigger_threshold_code <= RST_THRESHOLD;
      trigger_origin_code    <= RST_ORIGIN;
      trigger_direction      <= 1'b0;
      sampling_arm_bit       <= 1'b0;
      sample_clock_origin    <= RST_CLK_ORIGIN;
      freq_select            <= 1'b0;
    end else begin
      if (hit(reg_req, OFS_TRIGGER_MODE_SELECT)) begin
        trigger_mode_code <= reg_req.wdata[2:0];
      end
      if (hit(reg_req, OFS_TRIGGER_THRESHOLD)) begin
        trigger_threshold_code <= reg_req.wdata[7:0];
      end
      if (hit(reg_req, OFS_TRIGGER_ORIGIN_SLOPE)) begin
        trigger_origin_code <= reg_req.wdata[2:0];
        trigger_direction   <= reg_req.wdata[BIT_DIRECTION];
      end
      if (hit(reg_req, OFS_SAMPLING_ARM)) begin
        sampling_arm_bit <= reg_req.wdata[BIT_ARM];
      end
      if (hit(reg_req, OFS_SAMPLE_CLOCK_SELECT)) begin
        sample_clock_origin <= reg_req.wdata[2:1];
        // Only stored and driven out; software owns its meaning
        freq_select <= reg_req.wdata[BIT_FREQ_SELECT];
      end
    end
  end

  // Flush is a write side effect at the shared offset
  assign flush_req = hit(reg_req, OFS_BUFFER_STATE_CLEAR) &&
                     reg_req.wdata[BIT_FLUSH];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  // Two stages on every asynchronous pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_s1 <= 3'h0;
      clk_s2 <= 3'h0;
      trg_s1 <= 1'b0;
      trg_s2 <= 1'b0;
      adc_s1 <= '0;
      adc_s2 <= '0;
    end else begin
      clk_s1 <= {digital_clk_pin, sine_clk_pin, osc_clk_pin};
      clk_s2 <= clk_s1;
      trg_s1 <= external_logic_trigger_input;
      trg_s2 <= trg_s1;
      adc_s1 <= adc_sample;
      adc_s2 <= adc_s1;
    end
  end

  // Histories for edge detection, read from second stage only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_prev <= 3'h0;
      trg_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s2;
      trg_prev <= trg_s2;
    end
  end

  // ----------------------------------------------------------------
  // Sample clock divider
  // ----------------------------------------------------------------

  // Source clocks above half the core rate will alias; limitation
  always_comb begin
    unique case (dtac_clk_e'(sample_clock_origin))
      CLK_INTERNAL: src_edge = clk_s2[0] & ~clk_prev[0];
      CLK_SINE:     src_edge = clk_s2[1] & ~clk_prev[1];
      CLK_DIGITAL:  src_edge = clk_s2[2] & ~clk_prev[2];
      CLK_ILLEGAL:  src_edge = 1'b0;
    endcase
  end

  // Low bit forced to zero, values below the minimum clamp up
  always_comb begin
    divisor = {clock_divisor_value[15:1], 1'b0};
    if (divisor < DIVISOR_MIN) begin
      divisor = DIVISOR_MIN;
    end
  end

  // One tick every divisor source edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt     <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (src_edge) begin
        if (div_cnt >= divisor - 16'h0001) begin
          div_cnt     <= 16'h0000;
          sample_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger detection
  // ----------------------------------------------------------------

  // Channel picked by the low origin bits
  always_comb begin
    unique case (trigger_origin_code[1:0])
      2'b00: chan_now = adc_s2.ch0;
      2'b01: chan_now = adc_s2.ch1;
      2'b10: chan_now = adc_s2.ch2;
      2'b11: chan_now = adc_s2.ch3;
    endcase
  end

  // Channel history taken once per sample tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_prev    <= 8'h00;
      chan_prev_ok <= 1'b0;
    end else if (!waiting) begin
      // Fresh history each run so a stale value cannot fire
      chan_prev_ok <= 1'b0;
    end else if (sample_tick) begin
      chan_prev    <= chan_now;
      chan_prev_ok <= 1'b1;
    end
  end

  // Offset binary compares as plain unsigned codes
  always_comb begin
    if (!trigger_direction) begin
      analog_cross = (chan_prev < trigger_threshold_code) &&
                     (chan_now >= trigger_threshold_code);
    end else begin
      analog_cross = (chan_prev > trigger_threshold_code) &&
                     (chan_now <= trigger_threshold_code);
    end
  end

  // Pin edge polarity follows the direction bit, level unused
  assign digital_edge = trigger_direction ? (trg_prev & ~trg_s2)
                                          : (trg_s2 & ~trg_prev);

  // Top origin bit picks the pin over the channels
  assign trig_event = waiting &&
                      (trigger_origin_code[2] ? digital_edge
                       : (sample_tick && chan_prev_ok && analog_cross));

  // ----------------------------------------------------------------
  // Acquisition sequencer
  // ----------------------------------------------------------------

  assign waiting  = (state == ST_WAIT) || (state == ST_PRE);
  assign sampling = (state == ST_PRE) || (state == ST_SAMPLE) ||
                    (state == ST_POST);

  // Next state from mode, trigger and counter
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (sampling_arm_bit && mode_legal(trigger_mode_code) &&
            (sample_clock_origin != CLK_ILLEGAL)) begin
          unique case (dtac_mode_e'(trigger_mode_code))
            MODE_SOFTWARE: next_state = ST_SAMPLE;
            MODE_POST:     next_state = ST_WAIT;
            MODE_PRE:      next_state = ST_PRE;
            MODE_DELAY:    next_state = ST_WAIT;
            MODE_MIDDLE:   next_state = ST_PRE;
            default:       next_state = ST_IDLE;
          endcase
        end
      end
      ST_WAIT: begin
        if (trig_event) begin
          if (trigger_mode_code == MODE_DELAY) begin
            next_state = (after_trigger_count_value == 16'h0000)
                         ? ST_SAMPLE : ST_DELAY;
          end else begin
            next_state = ST_SAMPLE;
          end
        end
      end
      ST_PRE: begin
        if (trig_event) begin
          if (trigger_mode_code == MODE_MIDDLE) begin
            next_state = (after_trigger_count_value == 16'h0000)
                         ? ST_DONE : ST_POST;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_DELAY: begin
        if (after_trigger_count_value == 16'h0000) begin
          next_state = ST_SAMPLE;
        end
      end
      ST_POST: begin
        if (after_trigger_count_value == 16'h0000) begin
          next_state = ST_DONE;
        end
      end
      ST_SAMPLE: next_state = ST_SAMPLE;
      ST_DONE:   next_state = ST_DONE;
      default:   next_state = ST_IDLE;
    endcase
    // Disarm or a bad setting ends any run at once
    if (!sampling_arm_bit || !mode_legal(trigger_mode_code) ||
        (sample_clock_origin == CLK_ILLEGAL)) begin
      next_state = ST_IDLE;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Post-trigger counter
  // ----------------------------------------------------------------

  assign count_run = sample_tick &&
                     ((state == ST_DELAY) || (state == ST_POST));

  // Register write loads it, ticks after trigger count it down
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      after_trigger_count_value <= RST_COUNT;
    end else if (hit(reg_req, OFS_AFTER_TRIGGER_COUNT)) begin
      after_trigger_count_value <= reg_req.wdata[15:0];
    end else if (count_run && (after_trigger_count_value != 16'h0000)) begin
      after_trigger_count_value <= after_trigger_count_value - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Trigger seen flag
  // ----------------------------------------------------------------

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trigger_seen_flag <= 1'b0;
    end else if (trig_event ||
                 ((state == ST_IDLE) && (next_state == ST_SAMPLE))) begin
      trigger_seen_flag <= 1'b1;
    end else if (hit(reg_req, OFS_BUFFER_STATE_CLEAR) &&
                 reg_req.wdata[BIT_SEEN_CLEAR]) begin
      trigger_seen_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sample buffer bookkeeping
  // ----------------------------------------------------------------

  // Samples are dropped while the buffer is full
  assign buf_full = (buf_level == BUF_FULL);
  assign do_push  = sampling && sample_tick && !buf_full;
  assign do_pop   = buffer_pop && (buf_level != '0);

  // Occupancy of the external store; flush outranks traffic
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_level <= '0;
    end else if (flush_req) begin
      buf_level <= '0;
    end else if (do_push && !do_pop) begin
      buf_level <= buf_level + 16'h0001;
    end else if (do_pop && !do_push) begin
      buf_level <= buf_level - 16'h0001;
    end
  end

  // Sample word and strobes toward the store
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_push  <= 1'b0;
      sample_data  <= '0;
      buffer_flush <= 1'b0;
    end else begin
      sample_push  <= do_push;
      buffer_flush <= flush_req;
      if (do_push) begin
        sample_data <= adc_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status readback
  // ----------------------------------------------------------------

  assign sampling_active = sampling;

  // Read data held one cycle after the strobe; other offsets read zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_req.rd) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_req.addr == OFS_BUFFER_STATE_CLEAR) begin
        reg_rdata[BIT_CAN_ACCEPT]  <= !buf_full;
        reg_rdata[BIT_HALF_LEVEL]  <= (buf_level >= BUF_HALF);
        reg_rdata[BIT_HAS_ENTRIES] <= (buf_level != '0);
        reg_rdata[BIT_COUNT_DONE]  <=
          (after_trigger_count_value == 16'h0000);
        reg_rdata[BIT_SEEN_FLAG]   <= trigger_seen_flag;
        reg_rdata[BIT_ACTIVE]      <= sampling;
      end
    end
  end

endmodule

// ==== hdl/dtac_pkg.sv ====
// Notes on behaviour
// - Mode codes: software, post, pre, delay, middle.
// - Undefined mode code means no samples taken.
// - Level is offset binary, 0x80 zero volts.
// - Direction bit 0 rising, 1 falling.
// - Origin codes 0-3 channels, top bit external.
// - External input uses edges, ignores level.
// - Count register write loads 16-bit down counter.
// - Counter decrements per sample tick, stops at zero.
// - Counter gives delay or post-trigger sample count.
// - Status bit 0 means buffer not full.
// - Status bit 1 means at least half full.
// - Status bit 2 means buffer not empty.
// - Status bit 3 means counter at zero.
// - Status bit 4 trigger seen until cleared.
// - Status bit 5 high only while sampling.
// - Control bit 0 write flushes whole buffer.
// - Control bit 1 write clears trigger seen.
// - Arm bit 1 arms, 0 disables sampling.
// - Clock origin: internal, sine, digital, 11 illegal.
// - External sources pass the same divider.
// - Sample rate is source over even divisor, min 2.
// - Analog trigger on first crossing of level.
// - Pre mode samples from arm until trigger.
// - Delay mode samples after counter reaches zero.
package dtac_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TRIGGER_MODE_SELECT  = 8'h08;
  localparam logic [7:0] OFS_TRIGGER_THRESHOLD    = 8'h0c;
  localparam logic [7:0] OFS_TRIGGER_ORIGIN_SLOPE = 8'h10;
  localparam logic [7:0] OFS_AFTER_TRIGGER_COUNT  = 8'h14;
  localparam logic [7:0] OFS_BUFFER_STATE_CLEAR   = 8'h18;
  localparam logic [7:0] OFS_SAMPLING_ARM         = 8'h1c;
  localparam logic [7:0] OFS_SAMPLE_CLOCK_SELECT  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DIRECTION     = 3;
  localparam int BIT_FREQ_SELECT   = 0;
  localparam int BIT_FLUSH         = 0;
  localparam int BIT_SEEN_CLEAR    = 1;
  localparam int BIT_ARM           = 0;
  localparam int BIT_CAN_ACCEPT    = 0;
  localparam int BIT_HALF_LEVEL    = 1;
  localparam int BIT_HAS_ENTRIES   = 2;
  localparam int BIT_COUNT_DONE    = 3;
  localparam int BIT_SEEN_FLAG     = 4;
  localparam int BIT_ACTIVE        = 5;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [2:0]  RST_MODE       = 3'h0;
  localparam logic [7:0]  RST_THRESHOLD  = 8'h80;
  localparam logic [2:0]  RST_ORIGIN     = 3'h0;
  localparam logic [15:0] RST_COUNT      = 16'h0000;
  localparam logic [1:0]  RST_CLK_ORIGIN = 2'h0;
  localparam logic [15:0] DIVISOR_MIN    = 16'h0002;
  localparam int          BUF_DEPTH      = 32768;
  localparam int          BUF_AW         = 16;
  localparam logic [BUF_AW-1:0] BUF_FULL = 16'h8000;
  localparam logic [BUF_AW-1:0] BUF_HALF = 16'h4000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SOFTWARE = 3'b000,
    MODE_POST     = 3'b001,
    MODE_PRE      = 3'b010,
    MODE_DELAY    = 3'b011,
    MODE_MIDDLE   = 3'b100
  } dtac_mode_e;

  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'b00,
    CLK_SINE     = 2'b01,
    CLK_DIGITAL  = 2'b10,
    CLK_ILLEGAL  = 2'b11
  } dtac_clk_e;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT     = 3'b001,
    ST_PRE      = 3'b010,
    ST_DELAY    = 3'b011,
    ST_SAMPLE   = 3'b100,
    ST_POST     = 3'b101,
    ST_DONE     = 3'b110
  } dtac_state_e;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dtac_req_s;

  // Four 8-bit channel codes
  typedef struct packed {
    logic [7:0] ch3;
    logic [7:0] ch2;
    logic [7:0] ch1;
    logic [7:0] ch0;
  } dtac_sample_s;

endpackage

// ==== testbench/dtac_checker.sv ====
`timescale 1ns/1ps
module dtac_checker
  import dtac_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_b,
  // Register port
  input wire dtac_req_s   reg_req,
  input wire logic [31:0] reg_rdata,
  // Watched outputs
  input wire logic        buffer_flush,
  input wire logic        sample_push,
  input wire logic        sample_tick,
  input wire logic        sampling_active,
  input wire logic        freq_select
);
  // -------------------------------------------------
  // Decode helpers
  // -------------------------------------------------
  wire ctl_wr = reg_req.wr && reg_req.addr == OFS_BUFFER_STATE_CLEAR;
  wire arm_wr = reg_req.wr && reg_req.addr == OFS_SAMPLING_ARM;
  wire clk_wr = reg_req.wr && reg_req.addr == OFS_SAMPLE_CLOCK_SELECT;
  wire st_rd  = reg_req.rd && reg_req.addr == OFS_BUFFER_STATE_CLEAR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // -------------------------------------------------
  // Properties
  // -------------------------------------------------
  a_flush_on_write: assert property (ctl_wr && reg_req.wdata[0] |=> buffer_flush)
    else $error("flush pulse missing");
  a_flush_has_cause: assert property (buffer_flush |-> $past(ctl_wr && reg_req.wdata[0]))
    else $error("flush pulse without write");
  a_push_needs_tick: assert property (sample_push |-> $past(sample_tick))
    else $error("push without tick");
  a_tick_is_single: assert property (sample_tick |=> !sample_tick)
    else $error("tick longer than one cycle");
  a_active_in_status: assert property (st_rd |=> reg_rdata[5] == $past(sampling_active))
    else $error("status active bit wrong");
  a_disarm_goes_idle: assert property (arm_wr && !reg_req.wdata[0] |-> ##2 !sampling_active)
    else $error("still active after disarm");
  a_bad_clock_quiet: assert property (clk_wr && reg_req.wdata[2:1] == 2'b11 |-> ##4 !sample_tick [*8])
    else $error("tick with illegal clock");
  a_freq_sel_kept: assert property (clk_wr |=> freq_select == $past(reg_req.wdata[0]))
    else $error("frequency select not stored");
  // Main scenarios reached
  c_push: cover property (sample_push);
  c_flush: cover property (buffer_flush);
  c_seen: cover property (st_rd ##1 reg_rdata[4]);
endmodule
bind dtac_core dtac_checker dtac_checker_i (.core_clk(core_clk), .rst_b(rst_b),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .buffer_flush(buffer_flush),
  .sample_push(sample_push), .sample_tick(sample_tick),
  .sampling_active(sampling_active), .freq_select(freq_select));

// ==== testbench/test_digitizer_trigger_acq_control.sv ====
`timescale 1ns/1ps
module test_digitizer_trigger_acq_control
  import dtac_pkg::*;
;
  // Stimulus and observed signals
  logic core_clk = 0, rst_b = 0, osc = 0, sine = 0, dig = 0, ext = 0, pop = 0, d;
  dtac_req_s    req = '0;
  dtac_sample_s adc = '0;
  logic [15:0]  div = 16'h0002;
  logic [31:0]  rdata, st, r;
  logic         push, tick, act, fsel;
  int           miscompares = 0, cmp_count = 0, pc = 0, tc = 0, m;
  // Source clocks kept below half the core rate
  always #5 core_clk = ~core_clk;
  always #20 osc = ~osc;
  always #30 sine = ~sine;
  always #45 dig = ~dig;
  // Random converter codes, push and tick counting
  always @(posedge core_clk) begin
    adc <= $urandom;
    pc += push;
    tc += tick;
  end
  dtac_core dtac_core_i (.core_clk(core_clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
    .osc_clk_pin(osc), .sine_clk_pin(sine), .digital_clk_pin(dig),
    .clock_divisor_value(div), .external_logic_trigger_input(ext), .adc_sample(adc),
    .buffer_pop(pop), .sample_push(push), .sample_data(), .buffer_flush(),
    .sampling_active(act), .sample_tick(tick), .freq_select(fsel));
  // -------------------------------------------------
  // Register access and comparison tasks
  // -------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk) req <= '{1'b1, 1'b0, a, v};
    @(posedge core_clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk) req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge core_clk) req <= '0;
    #1 st = rdata;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Bounded wait on the active flag
  task automatic waitfor(input logic v);
    for (int i = 0; i < 3000 && act !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    check(act, v);
  endtask
  task automatic finish_test;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Expected flags after the trigger: active, seen, count done
  function automatic logic [2:0] after_trig(input int md);
    return {md == 1 || md == 3, 1'b1, md != 1 && md != 2};
  endfunction
  // Hang guard, well past the expected run
  initial begin
    #600000;
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(7));
    repeat (8) @(posedge core_clk);
    rst_b <= 1;
    // Edge trigger in post, delay, middle and pre modes
    for (int i = 0; i < 4; i++) begin
      m = i == 0 ? 1 : (i == 3 ? 2 : i + 2);
      d = i[0];
      @(posedge core_clk) begin
        ext <= !d;
        div <= 16'($urandom_range(1, 4) * 2);
      end
      wr(OFS_AFTER_TRIGGER_COUNT, 1 + $urandom % 4);
      wr(OFS_TRIGGER_ORIGIN_SLOPE, {d, 3'b100});
      wr(OFS_TRIGGER_MODE_SELECT, m);
      wr(OFS_SAMPLING_ARM, 0);
      wr(OFS_BUFFER_STATE_CLEAR, 2);
      wr(OFS_SAMPLING_ARM, 1);
      @(posedge core_clk) ext <= d;
      repeat (20) @(posedge core_clk);
      rd(OFS_BUFFER_STATE_CLEAR);
      check(st[5:3], {m == 4 || m == 2, 2'b00});
      @(posedge core_clk) ext <= !d;
      waitfor(m == 1 || m == 3);
      rd(OFS_BUFFER_STATE_CLEAR);
      check(st[5:3], after_trig(m));
    end
    // Analog origin: level 0x00 can never be crossed upward, 0x80 soon is
    for (int i = 0; i < 2; i++) begin
      wr(OFS_TRIGGER_MODE_SELECT, 1);
      wr(OFS_TRIGGER_THRESHOLD, i ? 32'h0000_0080 : 32'h0000_0000);
      wr(OFS_TRIGGER_ORIGIN_SLOPE, $urandom % 4);
      wr(OFS_SAMPLING_ARM, 0);
      wr(OFS_SAMPLING_ARM, 1);
      repeat (1000) @(posedge core_clk);
      #1 check(act, i);
    end
    // Undefined modes, then the illegal clock origin
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SAMPLE_CLOCK_SELECT, i < 3 ? 0 : 6);
      wr(OFS_TRIGGER_MODE_SELECT, i < 3 ? 5 + i : 0);
      wr(OFS_SAMPLING_ARM, 0);
      wr(OFS_SAMPLING_ARM, 1);
      pc = 0;
      tc = 0;
      repeat (200) @(posedge core_clk);
      check(pc + act + (i == 3 ? tc : 0), 0);
    end
    // Software trigger, drain by pops, flush and clear
    r = $urandom;
    wr(OFS_SAMPLE_CLOCK_SELECT, r & 32'h0000_0001);
    #1 check(fsel, r[0]);
    wr(OFS_SAMPLING_ARM, 0);
    wr(OFS_BUFFER_STATE_CLEAR, 3);
    pc = 0;
    wr(OFS_SAMPLING_ARM, 1);
    repeat (2) @(posedge core_clk);
    #1 check(act, 1);
    for (int j = 0; j < 2000 && pc < 5; j++) @(posedge core_clk);
    wr(OFS_SAMPLING_ARM, 0);
    repeat (4) @(posedge core_clk);
    rd(OFS_BUFFER_STATE_CLEAR);
    check(st & 32'hffff_fff7, 32'h0000_0015);
    for (int j = 0; j < pc; j++) begin
      @(posedge core_clk) pop <= 1;
      @(posedge core_clk) pop <= 0;
      rd(OFS_BUFFER_STATE_CLEAR);
      check(st[2], j < pc - 1);
    end
    wr(OFS_SAMPLING_ARM, 1);
    repeat (100) @(posedge core_clk);
    wr(OFS_SAMPLING_ARM, 0);
    wr(OFS_BUFFER_STATE_CLEAR, 1);
    rd(OFS_BUFFER_STATE_CLEAR);
    check(st[4:2], 3'b100);
    wr(OFS_BUFFER_STATE_CLEAR, 2);
    rd(OFS_BUFFER_STATE_CLEAR);
    check(st[4], 0);
    rd(8'h04);
    check(st, 0);
    finish_test();
  end
endmodule
